// >>> hw/ewm_pkg.sv
package ewm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  // Quarter of a serial clock period, rounded up to whole cycles
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [1:0] OFS_BUF_HI = 2'h1;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_LEN_LSB = 5;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_NACK_BIT = 2;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [3:0] LEN_RST = 4'h0;
  localparam logic [10:0] ADDR_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic DEV_TYPE = 1'b1;
  localparam int BUF_DEPTH = 16;
  typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_RND, OP_POLL} ewm_op_e;
  typedef enum logic [1:0] {B_START, B_STOP, B_WBIT, B_RBIT} ewm_bit_e;
  typedef struct packed {
    logic valid;
    ewm_bit_e op;
    logic din;
  } ewm_bcmd_s;
  typedef struct packed {
    logic done;
    logic rbit;
  } ewm_bres_s;
endpackage

// >>> hw/ewm_bit_eng.sv
`timescale 1ns/1ns
module ewm_bit_eng
(
  input logic clk,
  input logic rstn,
  input ewm_pkg::ewm_bcmd_s bcmd,
  output ewm_pkg::ewm_bres_s bres,
  input logic sda_i,
  output logic scl_out,
  output logic sda_drv
);
  logic sda_m_q;
  logic sda_s_q;
  logic busy_q;
  logic [1:0] ph_q;
  logic [7:0] tick_q;
  ewm_pkg::ewm_bit_e cmd_q;
  logic din_q;
  logic scl_q;
  logic oe_q;
  ewm_pkg::ewm_bres_s bres_q;

  wire logic tick_end = tick_q == ewm_pkg::QTR_LAST;
  wire logic ph_go = busy_q & (tick_q == 8'h00);
  wire logic ss_cmd = (cmd_q == ewm_pkg::B_START) | (cmd_q == ewm_pkg::B_STOP);
  // First quarter: set data while the clock is low
  wire logic oe0 = (cmd_q == ewm_pkg::B_STOP) | ((cmd_q == ewm_pkg::B_WBIT) & ~din_q);
  // Third quarter: only start and stop move data while the clock is high
  wire logic oe2 = (cmd_q == ewm_pkg::B_START) ? 1'b1 :
                   (cmd_q == ewm_pkg::B_STOP) ? 1'b0 : oe_q;

  assign scl_out = scl_q;
  assign sda_drv = oe_q;
  assign bres = bres_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      busy_q <= 1'b0;
      ph_q <= 2'h0;
      tick_q <= 8'h00;
      cmd_q <= ewm_pkg::B_STOP;
      din_q <= 1'b0;
    end
    else if (!busy_q)
    begin
      busy_q <= bcmd.valid;
      cmd_q <= bcmd.op;
      din_q <= bcmd.din;
      ph_q <= 2'h0;
      tick_q <= 8'h00;
    end
    else
    begin
      tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
      if (tick_end)
      begin
        ph_q <= ph_q + 2'h1;
        busy_q <= ph_q != 2'h3;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      scl_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else if (ph_go)
    begin
      case (ph_q)
        2'h0: oe_q <= oe0;
        2'h1: scl_q <= 1'b1;
        2'h2: oe_q <= oe2;
        default: scl_q <= cmd_q == ewm_pkg::B_STOP;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      bres_q <= '0;
    else
    begin
      bres_q.done <= busy_q & tick_end & (ph_q == 2'h3);
      if (ph_go && ph_q == 2'h2)
        bres_q.rbit <= sda_s_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_start_edge;
    busy_q && cmd_q == ewm_pkg::B_START && ph_q == 2'h2 && tick_q == 8'h00;
  endsequence
  sequence s_stop_edge;
    busy_q && cmd_q == ewm_pkg::B_STOP && ph_q == 2'h2 && tick_q == 8'h00;
  endsequence

  start_cond_a: assert property (s_start_edge |=> scl_q && $rose(oe_q))
    else $error("start did not pull data low under high clock");
  data_stable_a: assert property ($changed(oe_q) && $past(scl_q) |-> $past(ss_cmd))
    else $error("data moved while clock high outside start or stop");
  stop_cond_a: assert property (s_stop_edge |=> scl_q && !oe_q ##1 scl_q && !oe_q)
    else $error("stop did not release data under high clock");
endmodule

// >>> hw/ewm_master.sv
`timescale 1ns/1ns
// Summary of operation
// - Start: data falls while clock high
// - Data changes only while clock low
// - Stop: data rises while clock high
// - Stop only after transmitter released data
// - Receiver pulls data low on ninth clock
// - No acknowledge ends read; master stops
// - Slave address leading bit is one
// - Last address bit: one read, zero write
// - Byte write: word address, then data byte
// - Page write: up to sixteen bytes total
// - Poll busy device with write-direction address
module ewm_master
(
  input logic clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic scl_o,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_TXB, S_RXACK, S_RXB, S_TXACK, S_STOP} ewm_st_e;
  typedef enum logic [1:0] {G_DEV, G_WORD, G_DATA, G_RDEV} ewm_stage_e;

  function automatic ewm_pkg::ewm_bcmd_s mk_cmd(input ewm_pkg::ewm_bit_e op, input logic din);
    mk_cmd = '{valid: 1'b1, op: op, din: din};
  endfunction

  function automatic logic [7:0] dev_byte(input logic [2:0] sel, input logic [2:0] ahi,
                                          input logic rd);
    dev_byte = {ewm_pkg::DEV_TYPE, sel, ahi, rd};
  endfunction

  ewm_st_e st_q;
  ewm_st_e st_d;
  ewm_stage_e stage_q;
  ewm_stage_e stage_d;
  ewm_pkg::ewm_op_e op_q;
  logic [2:0] sel_q;
  logic [3:0] len_q;
  logic [10:0] addr_q;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [7:0] buf_q [ewm_pkg::BUF_DEPTH];
  ewm_pkg::ewm_bcmd_s bcmd_q;
  ewm_pkg::ewm_bcmd_s bcmd_d;
  ewm_pkg::ewm_bres_s bres;
  logic fin;
  logic nack_set;
  logic rx_we;
  logic done_q;
  logic nack_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sda_o_q;
  logic scl_w;
  logic oe_w;

  wire logic busy = st_q != S_IDLE;
  wire logic setup = psel & ~penable;
  wire logic wr = psel & penable & pready_q & pwrite;
  wire logic hit_ctrl = paddr == ewm_pkg::OFS_CTRL;
  wire logic hit_addr = paddr == ewm_pkg::OFS_ADDR;
  wire logic hit_stat = paddr == ewm_pkg::OFS_STAT;
  wire logic hit_buf = (paddr[7:6] == ewm_pkg::OFS_BUF_HI) & (paddr[1:0] == 2'h0);
  wire logic mapped = hit_ctrl | hit_addr | hit_stat | hit_buf;
  wire logic [3:0] bidx = paddr[5:2];
  // Commands and buffer writes are refused while a transfer runs
  wire logic go = wr & hit_ctrl & ~busy;
  wire logic addr_we = wr & hit_addr & ~busy;
  wire logic buf_we = wr & hit_buf & ~busy;
  wire logic done_clr = wr & hit_stat & pwdata[ewm_pkg::STAT_DONE_BIT];
  wire logic nack_clr = wr & hit_stat & pwdata[ewm_pkg::STAT_NACK_BIT];
  wire logic last = idx_q == len_q;
  // Direction bit: one for current reads and a random read's second address, zero otherwise
  wire logic rd_dir = (op_q == ewm_pkg::OP_READ_CUR) | (stage_q == G_RDEV);
  wire logic [7:0] dev_w = dev_byte(sel_q, addr_q[10:8], rd_dir);
  wire logic [7:0] rx_byte = {sh_q[6:0], bres.rbit};
  wire logic [7:0] nxt_data = buf_q[idx_q + 4'h1];
  wire logic [31:0] rd_ctrl = {23'h0, len_q, sel_q, op_q};
  wire logic [31:0] rd_stat = {29'h0, nack_q, done_q, busy};
  wire logic [31:0] rdata = hit_ctrl ? rd_ctrl :
                            hit_addr ? {21'h0, addr_q} :
                            hit_stat ? rd_stat :
                            hit_buf ? {24'h0, buf_q[bidx]} : 32'h0;

  ewm_bit_eng u_bit
  (
    .clk(clk),
    .rstn(rstn),
    .bcmd(bcmd_q),
    .bres(bres),
    .sda_i(sda_i),
    .scl_out(scl_w),
    .sda_drv(oe_w)
  );

  assign scl_o = scl_w;
  assign sda_oe = oe_w;
  assign sda_o = sda_o_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  always_comb
  begin
    st_d = st_q;
    stage_d = stage_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    bcmd_d = '0;
    fin = 1'b0;
    nack_set = 1'b0;
    rx_we = 1'b0;
    case (st_q)
      S_IDLE:
      begin
        if (go)
        begin
          st_d = S_START;
          stage_d = G_DEV;
          idx_d = 4'h0;
          bcmd_d = mk_cmd(ewm_pkg::B_START, 1'b0);
        end
      end
      S_START:
      begin
        if (bres.done)
        begin
          st_d = S_TXB;
          cnt_d = ewm_pkg::BIT_LAST;
          sh_d = dev_w;
          bcmd_d = mk_cmd(ewm_pkg::B_WBIT, dev_w[7]);
        end
      end
      S_TXB:
      begin
        if (bres.done)
        begin
          if (cnt_q == 3'h0)
          begin
            // Release data for the ninth clock and read the answer
            st_d = S_RXACK;
            bcmd_d = mk_cmd(ewm_pkg::B_RBIT, 1'b1);
          end
          else
          begin
            cnt_d = cnt_q - 3'h1;
            sh_d = {sh_q[6:0], 1'b0};
            bcmd_d = mk_cmd(ewm_pkg::B_WBIT, sh_q[6]);
          end
        end
      end
      S_RXACK:
      begin
        if (bres.done)
        begin
          if (bres.rbit)
          begin
            // No acknowledge, or device still busy writing
            nack_set = 1'b1;
            st_d = S_STOP;
            bcmd_d = mk_cmd(ewm_pkg::B_STOP, 1'b0);
          end
          else
          begin
            case (stage_q)
              G_DEV:
              begin
                if (op_q == ewm_pkg::OP_POLL)
                begin
                  st_d = S_STOP;
                  bcmd_d = mk_cmd(ewm_pkg::B_STOP, 1'b0);
                end
                else if (op_q == ewm_pkg::OP_READ_CUR)
                begin
                  st_d = S_RXB;
                  cnt_d = ewm_pkg::BIT_LAST;
                  bcmd_d = mk_cmd(ewm_pkg::B_RBIT, 1'b1);
                end
                else
                begin
                  stage_d = G_WORD;
                  st_d = S_TXB;
                  cnt_d = ewm_pkg::BIT_LAST;
                  sh_d = addr_q[7:0];
                  bcmd_d = mk_cmd(ewm_pkg::B_WBIT, addr_q[7]);
                end
              end
              G_WORD:
              begin
                if (op_q == ewm_pkg::OP_READ_RND)
                begin
                  stage_d = G_RDEV;
                  st_d = S_START;
                  bcmd_d = mk_cmd(ewm_pkg::B_START, 1'b0);
                end
                else
                begin
                  stage_d = G_DATA;
                  st_d = S_TXB;
                  cnt_d = ewm_pkg::BIT_LAST;
                  sh_d = buf_q[idx_q];
                  bcmd_d = mk_cmd(ewm_pkg::B_WBIT, buf_q[idx_q][7]);
                end
              end
              G_DATA:
              begin
                // Page holds at most sixteen bytes, counted by len
                if (last)
                begin
                  st_d = S_STOP;
                  bcmd_d = mk_cmd(ewm_pkg::B_STOP, 1'b0);
                end
                else
                begin
                  idx_d = idx_q + 4'h1;
                  st_d = S_TXB;
                  cnt_d = ewm_pkg::BIT_LAST;
                  sh_d = nxt_data;
                  bcmd_d = mk_cmd(ewm_pkg::B_WBIT, nxt_data[7]);
                end
              end
              default:
              begin
                st_d = S_RXB;
                cnt_d = ewm_pkg::BIT_LAST;
                bcmd_d = mk_cmd(ewm_pkg::B_RBIT, 1'b1);
              end
            endcase
          end
        end
      end
      S_RXB:
      begin
        if (bres.done)
        begin
          sh_d = rx_byte;
          if (cnt_q == 3'h0)
          begin
            // Acknowledge all but the last byte; the last gets none
            rx_we = 1'b1;
            st_d = S_TXACK;
            bcmd_d = mk_cmd(ewm_pkg::B_WBIT, last);
          end
          else
          begin
            cnt_d = cnt_q - 3'h1;
            bcmd_d = mk_cmd(ewm_pkg::B_RBIT, 1'b1);
          end
        end
      end
      S_TXACK:
      begin
        if (bres.done)
        begin
          if (last)
          begin
            st_d = S_STOP;
            bcmd_d = mk_cmd(ewm_pkg::B_STOP, 1'b0);
          end
          else
          begin
            idx_d = idx_q + 4'h1;
            st_d = S_RXB;
            cnt_d = ewm_pkg::BIT_LAST;
            bcmd_d = mk_cmd(ewm_pkg::B_RBIT, 1'b1);
          end
        end
      end
      S_STOP:
      begin
        if (bres.done)
        begin
          fin = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q <= S_IDLE;
      stage_q <= G_DEV;
      idx_q <= 4'h0;
      cnt_q <= 3'h0;
      sh_q <= ewm_pkg::BYTE_RST;
      bcmd_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      stage_q <= stage_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      bcmd_q <= bcmd_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      op_q <= ewm_pkg::OP_WRITE;
      sel_q <= ewm_pkg::SEL_RST;
      len_q <= ewm_pkg::LEN_RST;
      addr_q <= ewm_pkg::ADDR_RST;
    end
    else
    begin
      if (go)
      begin
        op_q <= ewm_pkg::ewm_op_e'(pwdata[ewm_pkg::CTRL_OP_LSB +: 2]);
        sel_q <= pwdata[ewm_pkg::CTRL_SEL_LSB +: 3];
        len_q <= pwdata[ewm_pkg::CTRL_LEN_LSB +: 4];
      end
      if (addr_we)
        addr_q <= pwdata[10:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      done_q <= fin | (done_q & ~done_clr);
      nack_q <= nack_set | (nack_q & ~nack_clr);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < ewm_pkg::BUF_DEPTH; i++)
        buf_q[i] <= ewm_pkg::BYTE_RST;
    end
    else if (rx_we)
      buf_q[idx_q] <= rx_byte;
    else if (buf_we)
      buf_q[bidx] <= pwdata[7:0];
  end

  // Answer in the first access cycle; data formed in the setup cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= rdata;
        pslverr_q <= ~mapped;
      end
      sda_o_q <= 1'b0;
    end
  end

  // Cycles spent in the stop state; a stop bit must end within one bit time plus eight cycles
  logic [10:0] stop_cnt_q;
  wire logic stop_late = stop_cnt_q > 11'(4 * ewm_pkg::QTR_CYC + 8);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      stop_cnt_q <= 11'h000;
    else if (st_q == S_STOP)
      stop_cnt_q <= stop_cnt_q + 11'h001;
    else
      stop_cnt_q <= 11'h000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_dev_sent;
    st_q == S_START && bres.done;
  endsequence
  sequence s_ack_ok;
    st_q == S_RXACK && bres.done && !bres.rbit;
  endsequence

  start_first_a: assert property (go |=> st_q == S_START && bcmd_q.valid &&
    bcmd_q.op == ewm_pkg::B_START)
    else $error("transfer did not open with a start");
  stop_release_a: assert property (st_d == S_STOP && st_q != S_STOP |->
    st_q == S_RXACK || st_q == S_TXACK)
    else $error("stop issued before the ninth clock ended");
  ack_slot_a: assert property (st_q == S_TXB && bres.done && cnt_q == 3'h0 |=>
    st_q == S_RXACK && bcmd_q.valid && bcmd_q.op == ewm_pkg::B_RBIT)
    else $error("data not released after eight bits");
  nack_last_a: assert property (st_q == S_RXB && bres.done && cnt_q == 3'h0 && last |=>
    st_q == S_TXACK && bcmd_q.din ##1 !bcmd_q.valid)
    else $error("last read byte was acknowledged");
  read_end_a: assert property (st_q == S_TXACK && bres.done && last |=>
    st_q == S_STOP && bcmd_q.op == ewm_pkg::B_STOP)
    else $error("no stop after final read byte");
  addr_msb_a: assert property (s_dev_sent |=> sh_q[7] == ewm_pkg::DEV_TYPE)
    else $error("slave address leading bit not one");
  dir_bit_a: assert property (s_dev_sent |=> sh_q[0] == $past(rd_dir))
    else $error("direction bit does not match operation");
  word_after_dev_a: assert property (s_ack_ok ##0 stage_q == G_DEV &&
    op_q != ewm_pkg::OP_POLL && op_q != ewm_pkg::OP_READ_CUR |=>
    stage_q == G_WORD && sh_q == addr_q[7:0])
    else $error("word address did not follow slave address");
  page_count_a: assert property (s_ack_ok ##0 stage_q == G_DATA && st_d == S_STOP |->
    idx_q == len_q)
    else $error("page write byte count differs from length");
  poll_stop_a: assert property (s_ack_ok ##0 op_q == ewm_pkg::OP_POLL |=>
    st_q == S_STOP)
    else $error("poll did not end with stop");
  stop_time_a: assert property (!stop_late)
    else $error("stop took longer than one bit");
  stop_end_a: assert property (st_q == S_STOP && bres.done |=> st_q == S_IDLE && done_q)
    else $error("stop did not finish the transfer");
endmodule

// >>> verif/ewm_eeprom_model.sv
`timescale 1ns/1ns
module ewm_eeprom_model
#(
  parameter int WR_CYC = 3000,
  parameter logic [2:0] PINS = 3'h5
)
(
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [2048];
  logic [10:0] ptr = 11'h000;
  logic [7:0] sh;
  logic [7:0] tx;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic txm = 1'b0;
  logic wrote = 1'b0;
  logic ackd = 1'b0;
  int ph = 0;
  int bytes = 0;
  time wr_end = 0;
  initial
  begin
    pull = 1'b0;
    for (int i = 0; i < 2048; i++)
      mem[i] = i[7:0] ^ 8'hA5;
  end
  // Start and stop are data edges while the clock is high
  always @(sda)
  begin
    if (scl === 1'b1 && sda === 1'b0)
    begin
      act = ($time >= wr_end);
      ph = -1;
      bytes = 0;
      txm = 0;
      rd = 0;
      pull = 0;
    end
    else if (scl === 1'b1 && sda === 1'b1)
    begin
      act = 0;
      pull = 0;
      if (wrote)
        wr_end = $time + WR_CYC * ewm_pkg::CLK_PERIOD_NS;
      wrote = 0;
    end
  end
  always @(posedge scl)
    if (act)
    begin
      if (ph < 8)
        sh = {sh[6:0], sda};
      else
        ackd = ~sda;
    end
  always @(negedge scl)
    if (act)
    begin
      if (ph == 7 && txm)
      begin
        pull = 0;
        ph = 8;
      end
      else if (ph == 7)
      begin
        ph = 8;
        pull = 1;
        if (bytes == 0)
        begin
          act = sh[7] && sh[6:4] == {PINS[2], ~PINS[1], PINS[0]};
          pull = act;
          if (act)
          begin
            ptr[10:8] = sh[3:1];
            rd = sh[0];
          end
        end
        else if (bytes == 1)
          ptr[7:0] = sh;
        else
        begin
          mem[ptr] = sh;
          ptr[3:0] = ptr[3:0] + 4'h1;
          wrote = 1;
        end
      end
      else if (ph == 8)
      begin
        ph = 0;
        pull = 0;
        bytes = bytes + 1;
        if (rd && (!txm || ackd))
        begin
          txm = 1;
          tx = mem[ptr];
          ptr = ptr + 11'h001;
          pull = ~tx[7];
        end
        else if (txm)
          act = 0;
      end
      else
      begin
        ph = ph + 1;
        if (txm)
          pull = ~tx[7 - ph];
      end
    end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ns
module tb;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic err;
  } ewm_row_s;
  logic clk = 1'b0;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_o;
  logic sda_o;
  logic sda_oe;
  logic pull;
  wire logic sda;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] r;
  logic e;
  logic nk;
  ewm_row_s rows[9] = '{
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h04, 32'h000005EF, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h000005EF, 1'b0},
    '{1'b1, 8'h40, 32'h000000C3, 32'h0, 1'b0},
    '{1'b1, 8'h44, 32'h0000005A, 32'h0, 1'b0},
    '{1'b0, 8'h40, 32'h0, 32'h000000C3, 1'b0},
    '{1'b1, 8'h0C, 32'h00000001, 32'h0, 1'b1},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h44, 32'h0, 32'h0000005A, 1'b0}
  };
  // Open-drain data line with pull-up
  assign sda = ~(sda_oe | pull);
  always #5 clk = ~clk;
  ewm_master i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_o(scl_o), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  ewm_eeprom_model i_mdl (.scl(scl_o), .sda(sda), .pull(pull));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Waits for the transfer to finish, returns its nack flag and clears both flags
  task automatic wait_done(output logic nack);
    logic [31:0] st;
    logic er;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ewm_pkg::OFS_STAT, 32'h0, st, er);
      n++;
    end
    while (st[ewm_pkg::STAT_DONE_BIT] !== 1'b1 && n < 40000);
    chk("done flag", {31'h0, st[ewm_pkg::STAT_DONE_BIT]}, 32'h1);
    nack = st[ewm_pkg::STAT_NACK_BIT];
    apb(1'b1, ewm_pkg::OFS_STAT, 32'h00000006, st, er);
  endtask
  task automatic xfer(input logic [31:0] ctrl, output logic nack);
    logic [31:0] st;
    logic er;
    apb(1'b1, ewm_pkg::OFS_CTRL, ctrl, st, er);
    wait_done(nack);
  endtask
  initial
  begin
    repeat (120000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    rstn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("scl idle", {31'h0, scl_o}, 32'h1);
    chk("sda idle", {31'h0, sda_oe}, 32'h0);
    chk("sda value", {31'h0, sda_o}, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w)
        chk("prdata", r, rows[i].exp);
      chk("pslverr", {31'h0, e}, {31'h0, rows[i].err});
    end
    $display("test registers done");
    // Two-byte page write from the last slot of a page, sel carries the inverted middle bit
    apb(1'b1, ewm_pkg::OFS_CTRL, 32'h0000003C, r, e);
    apb(1'b1, ewm_pkg::OFS_ADDR, 32'h00000123, r, e);
    apb(1'b0, ewm_pkg::OFS_ADDR, 32'h0, r, e);
    chk("addr while busy", r, 32'h000005EF);
    apb(1'b0, ewm_pkg::OFS_CTRL, 32'h0, r, e);
    chk("ctrl readback", r, 32'h0000003C);
    apb(1'b0, ewm_pkg::OFS_STAT, 32'h0, r, e);
    chk("busy flag", r, 32'h00000001);
    wait_done(nk);
    chk("write nack", {31'h0, nk}, 32'h0);
    chk("first byte", {24'h0, i_mdl.mem[11'h5EF]}, 32'h000000C3);
    chk("wrapped byte", {24'h0, i_mdl.mem[11'h5E0]}, 32'h0000005A);
    $display("test page write done");
    xfer(32'h0000001F, nk);
    chk("poll while busy", {31'h0, nk}, 32'h1);
    // Current read with the raw pin levels as select bits must not be answered
    xfer(32'h00000015, nk);
    chk("raw pin select", {31'h0, nk}, 32'h1);
    xfer(32'h0000001F, nk);
    chk("poll after write", {31'h0, nk}, 32'h0);
    $display("test polling done");
    apb(1'b1, ewm_pkg::OFS_ADDR, 32'h000005E0, r, e);
    xfer(32'h0000001E, nk);
    chk("read nack", {31'h0, nk}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("read byte", r, 32'h0000005A);
    $display("test random read done");
    // Reset inside a start bit, before the data line has moved
    apb(1'b1, ewm_pkg::OFS_CTRL, 32'h0000001F, r, e);
    repeat (50) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("scl after reset", {31'h0, scl_o}, 32'h1);
    chk("sda after reset", {31'h0, sda_oe}, 32'h0);
    apb(1'b0, ewm_pkg::OFS_STAT, 32'h0, r, e);
    chk("stat after reset", r, 32'h0);
    apb(1'b0, ewm_pkg::OFS_CTRL, 32'h0, r, e);
    chk("ctrl after reset", r, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("buf after reset", r, 32'h0);
    $display("test mid reset done");
    summarize();
  end
endmodule
